// >>> common/t8co_params.svh
`ifndef T8CO_PARAMS_SVH
`define T8CO_PARAMS_SVH
// register offsets in the processor i/o space
`define T8CO_ADDR_W 6
`define T8CO_OFF_CMP 6'h23
`define T8CO_OFF_CNT 6'h24
`define T8CO_OFF_CTL 6'h25
`define T8CO_OFF_FLG 6'h36
`define T8CO_OFF_MSK 6'h37
// control register fields
`define T8CO_CTL_FOC 7
`define T8CO_CTL_WGM0 6
`define T8CO_CTL_COM1 5
`define T8CO_CTL_COM0 4
`define T8CO_CTL_WGM1 3
`define T8CO_CTL_CS2 2
`define T8CO_CTL_CS0 0
// flag and mask fields
`define T8CO_BIT_CMP 1
`define T8CO_BIT_OVF 0
// reset values and counter limits
`define T8CO_RST_BYTE 8'h00
`define T8CO_RST_CTL 7'h00
`define T8CO_RST_BITS 2'h0
`define T8CO_CNT_MAX 8'hff
`define T8CO_CNT_BOT 8'h00
// prescaler: divide by 2**log
`define T8CO_PRESC_W 10
`define T8CO_DIV8_LOG 3
`define T8CO_DIV64_LOG 6
`define T8CO_DIV256_LOG 8
`define T8CO_DIV1024_LOG 10
`endif

// >>> common/t8co_pkg.sv
`include "t8co_params.svh"
package t8co_pkg;
   typedef enum logic [1:0] {
      WGM_NORMAL, WGM_PWM_PC, WGM_CTC, WGM_FAST
   } t8co_wgm_t;

   typedef enum logic {DIR_UP, DIR_DOWN} t8co_dir_t;

   function automatic t8co_wgm_t t8co_mode(input logic wgm1,
                                          input logic wgm0);
      unique case ({wgm1, wgm0})
         2'h0: return WGM_NORMAL;
         2'h1: return WGM_PWM_PC;
         2'h2: return WGM_CTC;
         2'h3: return WGM_FAST;
      endcase
   endfunction : t8co_mode

   // pin action for a compare event; inv swaps set and clear
   function automatic logic t8co_wave_act(input logic [1:0] com,
                                          input logic inv,
                                          input logic cur);
      unique case (com)
         2'h0: return cur;
         2'h1: return ~cur;
         2'h2: return inv;
         2'h3: return ~inv;
      endcase
   endfunction : t8co_wave_act
endpackage : t8co_pkg

// >>> common/t8co_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface t8co_tick_if;
   logic [3:0] div_tick;
   logic ext_fall;
   modport presc (output div_tick);
   modport edge_det (output ext_fall);
   modport core (input div_tick, input ext_fall);
endinterface : t8co_tick_if
`default_nettype wire

// >>> design/t8co_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8co_params.svh"
module t8co_prescaler (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   t8co_tick_if.presc tick_out
);
   import t8co_pkg::*;

   logic [`T8CO_PRESC_W-1:0] pre_r;
   logic [`T8CO_PRESC_W-1:0] pre_nxt;

   function automatic logic low_ones(input logic [9:0] v, input int n);
      logic [9:0] m;
      m = 10'((32'd1 << n) - 32'd1);
      return (v & m) == m;
   endfunction : low_ones

   // free running, shared by every divided selection
   always_comb begin
      pre_nxt = pre_r + 10'h001;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pre_r <= 10'h000;
      end else if (clk_en_in) begin
         pre_r <= pre_nxt;
      end
   end

   assign tick_out.div_tick[0] = low_ones(pre_r, `T8CO_DIV8_LOG);
   assign tick_out.div_tick[1] = low_ones(pre_r, `T8CO_DIV64_LOG);
   assign tick_out.div_tick[2] = low_ones(pre_r, `T8CO_DIV256_LOG);
   assign tick_out.div_tick[3] = low_ones(pre_r, `T8CO_DIV1024_LOG);
endmodule : t8co_prescaler
`default_nettype wire

// >>> design/t8co_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
module t8co_edge_sync (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic pin_in,
   t8co_tick_if.edge_det edge_out
);
   import t8co_pkg::*;

   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic fall_r;
   logic fall_nxt;

   // only sync_r and prev_r feed the detector, never meta_r
   always_comb begin
      fall_nxt = prev_r & ~sync_r;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         fall_r <= 1'b0;
      end else if (clk_en_in) begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
         fall_r <= fall_nxt;
      end
   end

   assign edge_out.ext_fall = fall_r;
endmodule : t8co_edge_sync
`default_nettype wire

// >>> design/t8co_timer.sv
// Notes on behaviour
// - a three-bit clock select picks stop, clk/1, or clk/8, /64, /256, /1024 from one shared prescaler.
// - the two highest select codes count falling edges of the external count pin.
// - the external pin counts whatever its port direction, so software may drive it.
// - the counter value register is 8-bit, readable and writable, reset to zero.
// - a write to the counter value suppresses the compare match of the next timer clock.
// - the 8-bit compare value is compared on each timer clock and feeds both the flag and the wave pin.
// - the compare match flag sets when the counter equals the compare value.
// - the compare flag clears on vector acknowledge or a written one; a written zero does nothing.
// - the overflow flag sets whenever the counter overflows.
// - the overflow flag clears on vector acknowledge or a written one.
// - in phase correct pwm the overflow flag sets on the direction change at zero instead.
// - the compare interrupt asks only while flag, its enable and the global enable are all set.
// - the overflow interrupt asks only while flag, its enable and the global enable are all set.
// - the mask register holds the compare enable in bit 1 and the overflow enable in bit 0, reset zero.
// - the flag register holds the compare flag in bit 1 and the overflow flag in bit 0, reset zero.
`timescale 1ns/100ps
`default_nettype none
`include "t8co_params.svh"
module t8co_timer (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic [`T8CO_ADDR_W-1:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_we_in,
   input wire logic io_re_in,
   output logic [7:0] io_rdata_out,
   input wire logic external_count_pin_in,
   input wire logic cpu_status_gie_in,
   input wire logic compare_ack_in,
   input wire logic overflow_ack_in,
   output logic compare_irq_out,
   output logic overflow_irq_out,
   output logic wave_output_pin_out,
   output logic wave_output_pin_oe_out
);
   import t8co_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // tick sources

   t8co_tick_if ticks ();

   t8co_prescaler u_presc (
      .clk_sys_in (clk_sys_in),
      .resetn_in (resetn_in),
      .clk_en_in (clk_en_in),
      .tick_out (ticks.presc)
   );

   t8co_edge_sync u_edge (
      .clk_sys_in (clk_sys_in),
      .resetn_in (resetn_in),
      .clk_en_in (clk_en_in),
      .pin_in (external_count_pin_in),
      .edge_out (ticks.edge_det)
   );

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [6:0] ctl_r;
   logic [6:0] ctl_nxt;
   logic [7:0] compare_value_r;
   logic [7:0] compare_value_nxt;
   logic [1:0] timer_irq_mask_r;
   logic [1:0] timer_irq_mask_nxt;
   logic [7:0] counter_value_r;
   logic [7:0] counter_value_nxt;
   t8co_dir_t dir_r;
   t8co_dir_t dir_nxt;
   logic block_r;
   logic block_nxt;
   logic [1:0] timer_irq_flags_r;
   logic [1:0] timer_irq_flags_nxt;
   logic wave_r;
   logic wave_nxt;
   logic wave_oe_r;
   logic wave_oe_nxt;
   logic cmp_irq_r;
   logic cmp_irq_nxt;
   logic ovf_irq_r;
   logic ovf_irq_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   logic wr_cmp;
   logic wr_cnt;
   logic wr_ctl;
   logic wr_flg;
   logic wr_msk;
   logic [2:0] count_clock_select;
   logic [1:0] com;
   t8co_wgm_t mode;
   logic pwm;
   logic tick;
   logic match;
   logic ovf_evt;
   logic bottom_evt;
   logic force_cmp;

   ////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic hit(input logic [`T8CO_ADDR_W-1:0] a);
      return io_we_in && (io_addr_in == a);
   endfunction : hit

   always_comb begin
      wr_cmp = hit(`T8CO_OFF_CMP);
      wr_cnt = hit(`T8CO_OFF_CNT);
      wr_ctl = hit(`T8CO_OFF_CTL);
      wr_flg = hit(`T8CO_OFF_FLG);
      wr_msk = hit(`T8CO_OFF_MSK);
      count_clock_select = ctl_r[`T8CO_CTL_CS2:`T8CO_CTL_CS0];
      com = ctl_r[`T8CO_CTL_COM1:`T8CO_CTL_COM0];
      mode = t8co_mode(ctl_r[`T8CO_CTL_WGM1], ctl_r[`T8CO_CTL_WGM0]);
      pwm = (mode == WGM_PWM_PC) || (mode == WGM_FAST);
   end

   // timer clock enable; the shared prescaler is never cleared, so the first
   // divided tick after a select change may land anywhere in one period
   always_comb begin
      unique case (count_clock_select)
         3'h0: tick = 1'b0;
         3'h1: tick = 1'b1;
         3'h2: tick = ticks.div_tick[0];
         3'h3: tick = ticks.div_tick[1];
         3'h4: tick = ticks.div_tick[2];
         3'h5: tick = ticks.div_tick[3];
         // both top codes count falling pin edges, rising edges are ignored;
         // the pin is sampled regardless of its port direction
         3'h6, 3'h7: tick = ticks.ext_fall;
      endcase
   end

   // comparison uses the value held before this tick's step
   always_comb begin
      match = tick && !block_r && (counter_value_r == compare_value_r);
      force_cmp = wr_ctl && io_wdata_in[`T8CO_CTL_FOC] && !pwm;
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers

   always_comb begin
      ctl_nxt = ctl_r;
      compare_value_nxt = compare_value_r;
      timer_irq_mask_nxt = timer_irq_mask_r;
      if (wr_ctl) begin
         ctl_nxt = io_wdata_in[6:0];
      end
      if (wr_cmp) begin
         compare_value_nxt = io_wdata_in;
      end
      if (wr_msk) begin
         timer_irq_mask_nxt = io_wdata_in[1:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctl_r <= `T8CO_RST_CTL;
         compare_value_r <= `T8CO_RST_BYTE;
         timer_irq_mask_r <= `T8CO_RST_BITS;
      end else if (clk_en_in) begin
         ctl_r <= ctl_nxt;
         compare_value_r <= compare_value_nxt;
         timer_irq_mask_r <= timer_irq_mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // counter

   always_comb begin
      counter_value_nxt = counter_value_r;
      dir_nxt = dir_r;
      block_nxt = block_r;
      ovf_evt = 1'b0;
      bottom_evt = 1'b0;
      if (wr_cnt) begin
         // a write beats the step and masks the next match
         counter_value_nxt = io_wdata_in;
         block_nxt = 1'b1;
      end else if (tick) begin
         block_nxt = 1'b0;
         unique case (mode)
            WGM_PWM_PC: begin
               if (dir_r == DIR_UP) begin
                  if (counter_value_r == `T8CO_CNT_MAX) begin
                     dir_nxt = DIR_DOWN;
                     counter_value_nxt = counter_value_r - 8'h01;
                  end else begin
                     counter_value_nxt = counter_value_r + 8'h01;
                  end
               end else begin
                  if (counter_value_r == `T8CO_CNT_BOT) begin
                     dir_nxt = DIR_UP;
                     counter_value_nxt = counter_value_r + 8'h01;
                     ovf_evt = 1'b1;
                  end else begin
                     counter_value_nxt = counter_value_r - 8'h01;
                  end
               end
            end
            WGM_CTC: begin
               if (counter_value_r == compare_value_r) begin
                  counter_value_nxt = `T8CO_CNT_BOT;
               end else begin
                  counter_value_nxt = counter_value_r + 8'h01;
               end
               ovf_evt = (counter_value_r == `T8CO_CNT_MAX);
            end
            default: begin
               counter_value_nxt = counter_value_r + 8'h01;
               ovf_evt = (counter_value_r == `T8CO_CNT_MAX);
               bottom_evt = ovf_evt;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         counter_value_r <= `T8CO_RST_BYTE;
         dir_r <= DIR_UP;
         block_r <= 1'b0;
      end else if (clk_en_in) begin
         counter_value_r <= counter_value_nxt;
         dir_r <= dir_nxt;
         block_r <= block_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags: a hardware set in the clearing cycle wins

   always_comb begin
      logic [1:0] clr;
      logic [1:0] set;
      clr = 2'h0;
      set = 2'h0;
      if (wr_flg) begin
         clr = io_wdata_in[1:0];
      end
      clr[`T8CO_BIT_CMP] = clr[`T8CO_BIT_CMP] | compare_ack_in;
      clr[`T8CO_BIT_OVF] = clr[`T8CO_BIT_OVF] | overflow_ack_in;
      set[`T8CO_BIT_CMP] = match;
      set[`T8CO_BIT_OVF] = ovf_evt;
      timer_irq_flags_nxt = (timer_irq_flags_r & ~clr) | set;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         timer_irq_flags_r <= `T8CO_RST_BITS;
      end else if (clk_en_in) begin
         timer_irq_flags_r <= timer_irq_flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // waveform pin

   always_comb begin
      wave_nxt = wave_r;
      wave_oe_nxt = (com != 2'h0);
      if (force_cmp) begin
         // forced compare touches the pin only, never a flag
         wave_nxt = t8co_wave_act(com, 1'b0, wave_r);
      end else if (pwm && com == 2'h1) begin
         wave_nxt = wave_r;
      end else if (match) begin
         unique case (mode)
            WGM_PWM_PC: begin
               wave_nxt = t8co_wave_act(com, dir_r == DIR_DOWN, wave_r);
            end
            default: begin
               wave_nxt = t8co_wave_act(com, 1'b0, wave_r);
            end
         endcase
      end else if (mode == WGM_FAST && bottom_evt) begin
         wave_nxt = t8co_wave_act(com, 1'b1, wave_r);
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wave_r <= 1'b0;
         wave_oe_r <= 1'b0;
      end else if (clk_en_in) begin
         wave_r <= wave_nxt;
         wave_oe_r <= wave_oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt requests and read data

   always_comb begin
      cmp_irq_nxt = timer_irq_flags_r[`T8CO_BIT_CMP] &&
                    timer_irq_mask_r[`T8CO_BIT_CMP] &&
                    cpu_status_gie_in;
      ovf_irq_nxt = timer_irq_flags_r[`T8CO_BIT_OVF] &&
                    timer_irq_mask_r[`T8CO_BIT_OVF] &&
                    cpu_status_gie_in;
      rdata_nxt = rdata_r;
      if (io_re_in) begin
         unique case (io_addr_in)
            `T8CO_OFF_CMP: rdata_nxt = compare_value_r;
            `T8CO_OFF_CNT: rdata_nxt = counter_value_r;
            // force strobe always reads zero
            `T8CO_OFF_CTL: rdata_nxt = {1'b0, ctl_r};
            `T8CO_OFF_FLG: rdata_nxt = {6'h00, timer_irq_flags_r};
            `T8CO_OFF_MSK: rdata_nxt = {6'h00, timer_irq_mask_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmp_irq_r <= 1'b0;
         ovf_irq_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (clk_en_in) begin
         cmp_irq_r <= cmp_irq_nxt;
         ovf_irq_r <= ovf_irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // every output is a flop so the pins carry no decode glitches
   assign io_rdata_out = rdata_r;
   assign compare_irq_out = cmp_irq_r;
   assign overflow_irq_out = ovf_irq_r;
   assign wave_output_pin_out = wave_r;
   assign wave_output_pin_oe_out = wave_oe_r;
endmodule : t8co_timer
`default_nettype wire

// >>> bench/t8co_timer_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8co_params.svh"
module t8co_timer_sva (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic [`T8CO_ADDR_W-1:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_we_in,
   input wire logic io_re_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic external_count_pin_in,
   input wire logic cpu_status_gie_in,
   input wire logic compare_ack_in,
   input wire logic overflow_ack_in,
   input wire logic compare_irq_out,
   input wire logic overflow_irq_out,
   input wire logic wave_output_pin_out,
   input wire logic wave_output_pin_oe_out
);
   logic wr_ok;
   logic [1:0] msk_r;
   logic [7:0] ctl_r;
   assign wr_ok = io_we_in && clk_en_in;
   ////////////////////////////////////////////////////////////////////////
   // shadow copies let a request be traced back to the enables behind it
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         msk_r <= 2'h0;
         ctl_r <= 8'h00;
      end else if (wr_ok && io_addr_in == `T8CO_OFF_MSK) begin
         msk_r <= io_wdata_in[1:0];
      end else if (wr_ok && io_addr_in == `T8CO_OFF_CTL) begin
         ctl_r <= io_wdata_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   a_cmp_irq_gate: assert property (
      compare_irq_out && $past(clk_en_in)
      |-> $past(cpu_status_gie_in) && $past(msk_r[1]))
      else $error("compare request without its enables");
   a_ovf_irq_gate: assert property (
      overflow_irq_out && $past(clk_en_in)
      |-> $past(cpu_status_gie_in) && $past(msk_r[0]))
      else $error("overflow request without its enables");
   a_cmp_ack_clear: assert property (
      clk_en_in && compare_ack_in && !io_we_in && ctl_r[2:0] == 3'h0
      |-> ##2 !compare_irq_out)
      else $error("compare request survives acknowledge");
   a_ovf_ack_clear: assert property (
      clk_en_in && overflow_ack_in && !io_we_in && ctl_r[2:0] == 3'h0
      |-> ##2 !overflow_irq_out)
      else $error("overflow request survives acknowledge");
   a_ovf_w1c_clear: assert property (
      wr_ok && io_addr_in == `T8CO_OFF_FLG && io_wdata_in[0]
      && ctl_r[2:0] == 3'h0 |-> ##2 !overflow_irq_out)
      else $error("overflow request survives written one");
   a_rdata_hold: assert property (
      !($past(io_re_in) && $past(clk_en_in)) |-> $stable(io_rdata_out))
      else $error("read data moved without a read");
   a_cnt_readback: assert property (
      wr_ok && io_addr_in == `T8CO_OFF_CNT && ctl_r[2:0] == 3'h0
      ##2 clk_en_in && io_re_in && !io_we_in
      && io_addr_in == `T8CO_OFF_CNT
      |=> io_rdata_out == $past(io_wdata_in, 3))
      else $error("stopped counter does not read back");
   a_oe_follow: assert property (
      wr_ok && io_addr_in == `T8CO_OFF_CTL && io_wdata_in[5:4] != 2'h0
      |-> ##[1:2] wave_output_pin_oe_out)
      else $error("wave pin not enabled by output mode");
endmodule : t8co_timer_sva
bind t8co_timer t8co_timer_sva t8co_timer_sva_inst (
   .clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in),
   .clk_en_in(clk_en_in),
   .io_addr_in(io_addr_in),
   .io_wdata_in(io_wdata_in),
   .io_we_in(io_we_in),
   .io_re_in(io_re_in),
   .io_rdata_out(io_rdata_out),
   .external_count_pin_in(external_count_pin_in),
   .cpu_status_gie_in(cpu_status_gie_in),
   .compare_ack_in(compare_ack_in),
   .overflow_ack_in(overflow_ack_in),
   .compare_irq_out(compare_irq_out),
   .overflow_irq_out(overflow_irq_out),
   .wave_output_pin_out(wave_output_pin_out),
   .wave_output_pin_oe_out(wave_output_pin_oe_out)
);
`default_nettype wire

// >>> bench/t8co_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "t8co_params.svh"
module t8co_timer_bench;
   localparam logic [5:0] off_cmp = `T8CO_OFF_CMP;
   localparam logic [5:0] off_cnt = `T8CO_OFF_CNT;
   localparam logic [5:0] off_ctl = `T8CO_OFF_CTL;
   localparam logic [5:0] off_flg = `T8CO_OFF_FLG;
   localparam logic [5:0] off_msk = `T8CO_OFF_MSK;
   logic clk_sys_in, resetn_in, clk_en_in, io_we_in, io_re_in;
   logic [5:0] io_addr_in;
   logic [7:0] io_wdata_in, io_rdata_out, rd_val;
   logic external_count_pin_in, cpu_status_gie_in;
   logic compare_ack_in, overflow_ack_in, compare_irq_out;
   logic overflow_irq_out, wave_output_pin_out, wave_output_pin_oe_out;
   int failures = 0;
   int num_checks = 0;
   int lg[6] = '{0, 0, `T8CO_DIV8_LOG, `T8CO_DIV64_LOG, `T8CO_DIV256_LOG,
                 `T8CO_DIV1024_LOG};
   logic [5:0] offs[5] = '{off_cmp, off_cnt, off_flg, off_msk, 6'h10};
   t8co_timer t8co_timer_inst (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .clk_en_in(clk_en_in),
      .io_addr_in(io_addr_in),
      .io_wdata_in(io_wdata_in),
      .io_we_in(io_we_in),
      .io_re_in(io_re_in),
      .io_rdata_out(io_rdata_out),
      .external_count_pin_in(external_count_pin_in),
      .cpu_status_gie_in(cpu_status_gie_in),
      .compare_ack_in(compare_ack_in),
      .overflow_ack_in(overflow_ack_in),
      .compare_irq_out(compare_irq_out),
      .overflow_irq_out(overflow_irq_out),
      .wave_output_pin_out(wave_output_pin_out),
      .wave_output_pin_oe_out(wave_output_pin_oe_out)
   );
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : idle
   // every access leaves one quiet edge before the next
   task automatic acc(input logic we, input logic [5:0] a,
                      input logic [7:0] d);
      idle(1);
      io_we_in = we;
      io_re_in = !we;
      io_addr_in = a;
      io_wdata_in = d;
      idle(1);
      io_we_in = 1'b0;
      io_re_in = 1'b0;
      rd_val = io_rdata_out;
   endtask : acc
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(rd_val, e);
   endtask : rd
   // the counter sees n + 2 timer clocks between go and halt
   task automatic run(input logic [7:0] c0, input logic [7:0] go,
                      input int n, input logic [7:0] halt);
      wr(off_cnt, c0); // rewritten only while halted
      wr(off_ctl, go);
      repeat (n) @(posedge clk_sys_in);
      wr(off_ctl, halt);
   endtask : run
   task automatic pulse(input logic ovf);
      idle(1);
      compare_ack_in = !ovf;
      overflow_ack_in = ovf;
      idle(1);
      compare_ack_in = 1'b0;
      overflow_ack_in = 1'b0;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      failures++;
      results();
   end
   initial begin
      resetn_in = 1'b0;
      clk_en_in = 1'b1;
      io_we_in = 1'b0;
      io_re_in = 1'b0;
      io_addr_in = 6'h00;
      io_wdata_in = 8'h00;
      external_count_pin_in = 1'b1;
      cpu_status_gie_in = 1'b0;
      compare_ack_in = 1'b0;
      overflow_ack_in = 1'b0;
      idle(6);
      resetn_in = 1'b1;
      foreach (offs[i]) begin
         rd(offs[i], 8'h00);
      end
      wr(off_cmp, 8'ha5);
      rd(off_cmp, 8'ha5);
      wr(off_msk, 8'h03);
      rd(off_msk, 8'h03);
      wr(off_msk, 8'h00);
      // disabled cycles freeze the prescaler too, so two periods give two
      for (int c = 1; c < 6; c++) begin
         wr(off_cnt, 8'h00);
         wr(off_ctl, 8'(c));
         clk_en_in = 1'b0;
         idle(4);
         clk_en_in = 1'b1;
         repeat ((2 << lg[c]) - 2) @(posedge clk_sys_in);
         wr(off_ctl, 8'h00);
         rd(off_cnt, 8'h02);
      end
      run(8'h5a, 8'h00, 20, 8'h00);
      rd(off_cnt, 8'h5a);
      wr(off_cnt, 8'h00);
      rd(off_cnt, 8'h00);
      for (int c = 6; c < 8; c++) begin
         wr(off_ctl, 8'(c));
         repeat (3) begin
            external_count_pin_in = 1'b0;
            idle(5);
            external_count_pin_in = 1'b1;
            idle(5);
         end
         idle(8);
         wr(off_ctl, 8'h00);
         rd(off_cnt, 8'(3 * (c - 5)));
      end
      wr(off_cmp, 8'h05);
      run(8'h05, 8'h01, 0, 8'h00);
      rd(off_flg, 8'h00);
      rd(off_cnt, 8'h07);
      run(8'h03, 8'h11, 1, 8'h10);
      rd(off_flg, 8'h02);
      chk({7'h0, wave_output_pin_out}, 8'h01);
      chk({7'h0, wave_output_pin_oe_out}, 8'h01);
      chk({7'h0, compare_irq_out}, 8'h00);
      wr(off_msk, 8'h02);
      cpu_status_gie_in = 1'b1;
      idle(3);
      chk({7'h0, compare_irq_out}, 8'h01);
      cpu_status_gie_in = 1'b0;
      idle(3);
      chk({7'h0, compare_irq_out}, 8'h00);
      cpu_status_gie_in = 1'b1;
      wr(off_flg, 8'h00);
      rd(off_flg, 8'h02);
      wr(off_flg, 8'h02);
      rd(off_flg, 8'h00);
      run(8'h03, 8'h11, 1, 8'h10);
      chk({7'h0, wave_output_pin_out}, 8'h00);
      pulse(1'b0);
      rd(off_flg, 8'h00);
      chk({7'h0, compare_irq_out}, 8'h00);
      // forced compare toggles the pin in a non-pwm mode, no flag
      wr(off_ctl, 8'h90);
      chk({7'h0, wave_output_pin_out}, 8'h01);
      wr(off_msk, 8'h01);
      run(8'hfe, 8'h01, 0, 8'h00);
      rd(off_cnt, 8'h00);
      rd(off_flg, 8'h01);
      chk({7'h0, overflow_irq_out}, 8'h01);
      pulse(1'b1);
      rd(off_flg, 8'h00);
      run(8'hfe, 8'h01, 0, 8'h00);
      wr(off_flg, 8'h01);
      rd(off_flg, 8'h00);
      chk({7'h0, overflow_irq_out}, 8'h00);
      run(8'hfe, 8'h41, 2, 8'h40);
      acc(1'b0, off_flg, 8'h00);
      chk({7'h0, rd_val[0]}, 8'h00);
      run(8'hfe, 8'h41, 300, 8'h40);
      acc(1'b0, off_flg, 8'h00);
      chk({7'h0, rd_val[0]}, 8'h01);
      results();
   end
endmodule : t8co_timer_bench
`default_nettype wire
